// ### logic/ftu_frame_timer.sv
`timescale 1ns/10ps
`default_nettype none
module ftu_frame_timer (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic [31:0] timer_control_one_i,
	input wire logic software_sync_trigger_i,
	input wire logic rp1_sync_i,
	input wire logic rx_frame_boundary_i,
	input wire logic link_sync_input_i,
	input wire logic radio_sync_input_i,
	input wire logic [ftu_pkg::CLK_W-1:0] clk_terminal_i,
	input wire logic [ftu_pkg::SYM_W-1:0] sym_terminal_i,
	input wire logic [ftu_pkg::FRM_W-1:0] frm_terminal_i,
	input wire logic [ftu_pkg::CLK_W-1:0] rclk_terminal_i,
	input wire logic [ftu_pkg::SYM_W-1:0] rsym_terminal_i,
	input wire logic [ftu_pkg::FRM_W-1:0] rfrm_terminal_i,
	input wire logic [ftu_pkg::CLK_W-1:0] radio_sync_compare_value_i,
	input wire logic [ftu_pkg::CLK_W-1:0] tx_delta_i,
	input wire logic [ftu_pkg::CLK_W-1:0] rx_win_min_i,
	input wire logic [ftu_pkg::CLK_W-1:0] rx_win_max_i,
	input wire logic [ftu_pkg::CLK_W-1:0] uplink_offset_i,
	input wire logic [ftu_pkg::CLK_W-1:0] downlink_offset_i,
	input wire logic [ftu_pkg::NUM_EVT-1:0] event_enable_i,
	input wire logic [ftu_pkg::NUM_EVT*ftu_pkg::STB_W-1:0] event_strobe_sel_i,
	input wire logic [ftu_pkg::NUM_EVT*ftu_pkg::EVT_W-1:0] event_offset_i,
	input wire logic [ftu_pkg::NUM_EVT*ftu_pkg::EVT_W-1:0] event_modulo_i,
	output logic [ftu_pkg::CLK_W-1:0] link_clk_count_o,
	output logic [ftu_pkg::FRM_W-1:0] link_frame_count_o,
	output logic [ftu_pkg::CLK_W-1:0] radio_clk_count_o,
	output logic link_frame_strobe_o,
	output logic radio_symbol_strobe_o,
	output logic radio_frame_strobe_o,
	output logic uplink_symbol_strobe_o,
	output logic uplink_frame_strobe_o,
	output logic downlink_symbol_strobe_o,
	output logic downlink_frame_strobe_o,
	output logic tx_launch_o,
	output logic rx_in_window_o,
	output logic [ftu_pkg::NUM_EVT-1:0] event_o
);
	import ftu_pkg::*;
	typedef struct packed {
		logic [1:0] lpin;
		logic [1:0] rpin;
		logic lpin_d;
		logic rpin_d;
		logic [CLK_W-1:0] lc;
		logic [SYM_W-1:0] ls;
		logic [FRM_W-1:0] lf;
		logic lfb;
		logic [CLK_W-1:0] rc;
		logic [SYM_W-1:0] rs;
		logic [FRM_W-1:0] rf;
		logic rsb;
		logic rfb;
		logic [CLK_W-1:0] uc;
		logic [SYM_W-1:0] us;
		logic usb;
		logic ufb;
		logic [CLK_W-1:0] dc;
		logic [SYM_W-1:0] ds;
		logic dsb;
		logic dfb;
		logic tx;
		logic rxw;
	} ftu_tm_type;
	ftu_tm_type r, next_r;
	logic link_sync, radio_sync, cmp_hit;
	logic [5:0] strobes;
	function automatic logic [CLK_W-1:0] wrap_add(input logic [CLK_W-1:0] a,
		input logic [CLK_W-1:0] b, input logic [CLK_W-1:0] term);
		logic [CLK_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s > {1'b0, term}) begin
			s = s - {1'b0, term} - {{CLK_W{1'b0}}, 1'b1};
		end
		return s[CLK_W-1:0];
	endfunction
	always_comb begin
		link_sync = 1'b0;
		case (timer_control_one_i[CTL_LINK_LSB +: 2])
			SYNC_RP1: link_sync = rp1_sync_i;
			SYNC_PIN: link_sync = r.lpin[1] & ~r.lpin_d;
			SYNC_SW: link_sync = software_sync_trigger_i;
			SYNC_RXFB: link_sync = rx_frame_boundary_i;
			default: link_sync = 1'b0;
		endcase
	end
	assign cmp_hit = (r.lc == radio_sync_compare_value_i);
	always_comb begin
		radio_sync = 1'b0;
		case (timer_control_one_i[CTL_RAD_LSB +: 3])
			{1'b0, SYNC_RP1}: radio_sync = rp1_sync_i;
			{1'b0, SYNC_PIN}: radio_sync = r.rpin[1] & ~r.rpin_d;
			{1'b0, SYNC_SW}: radio_sync = software_sync_trigger_i;
			{1'b0, SYNC_RXFB}: radio_sync = rx_frame_boundary_i;
			RSYNC_CMP: radio_sync = cmp_hit;
			default: radio_sync = 1'b0;
		endcase
	end
	always_comb begin
		logic [CLK_W-1:0] ucn, dcn;
		next_r = r;
		ucn = '0;
		dcn = '0;
		next_r.lpin = {r.lpin[0], link_sync_input_i};
		next_r.rpin = {r.rpin[0], radio_sync_input_i};
		next_r.lpin_d = r.lpin[1];
		next_r.rpin_d = r.rpin[1];
		// link timer, independent of radio timer
		next_r.lfb = 1'b0;
		next_r.lc = r.lc + 1'b1;
		if (r.lc == clk_terminal_i) begin
			next_r.lc = '0;
			next_r.ls = r.ls + 1'b1;
			if (r.ls == sym_terminal_i) begin
				next_r.ls = '0;
				next_r.lfb = 1'b1;
				next_r.lf = (r.lf == frm_terminal_i) ? '0 : r.lf + 1'b1;
			end
		end
		if (link_sync) begin
			next_r.lc = '0;
			next_r.ls = '0;
			next_r.lf = '0;
			next_r.lfb = 1'b1;
		end
		// radio timer
		next_r.rsb = 1'b0;
		next_r.rfb = 1'b0;
		next_r.rc = r.rc + 1'b1;
		if (r.rc == rclk_terminal_i) begin
			next_r.rc = '0;
			next_r.rsb = 1'b1;
			next_r.rs = r.rs + 1'b1;
			if (r.rs == rsym_terminal_i) begin
				next_r.rs = '0;
				next_r.rfb = 1'b1;
				next_r.rf = (r.rf == rfrm_terminal_i) ? '0 : r.rf + 1'b1;
			end
		end
		if (radio_sync) begin
			next_r.rc = '0;
			next_r.rs = '0;
			next_r.rf = '0;
			next_r.rsb = 1'b1;
			next_r.rfb = 1'b1;
		end
		// uplink and downlink copies
		ucn = wrap_add(next_r.rc, uplink_offset_i, rclk_terminal_i);
		dcn = wrap_add(next_r.rc, downlink_offset_i, rclk_terminal_i);
		next_r.uc = ucn;
		next_r.dc = dcn;
		next_r.usb = (ucn == '0);
		next_r.dsb = (dcn == '0);
		next_r.us = (ucn == '0) ? ((r.us == rsym_terminal_i) ? '0 : r.us + 1'b1) : r.us;
		next_r.ds = (dcn == '0) ? ((r.ds == rsym_terminal_i) ? '0 : r.ds + 1'b1) : r.ds;
		next_r.ufb = (ucn == '0) && (r.us == rsym_terminal_i);
		next_r.dfb = (dcn == '0) && (r.ds == rsym_terminal_i);
		// link timer references
		next_r.tx = (next_r.lc == tx_delta_i);
		next_r.rxw = (next_r.lc >= rx_win_min_i) && (next_r.lc <= rx_win_max_i);
	end
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign strobes = {r.dfb, r.dsb, r.ufb, r.usb, r.rfb, r.rsb};
	for (genvar i = 0; i < NUM_EVT; i++) begin : g_evt
		logic [STB_W-1:0] sel;
		assign sel = event_strobe_sel_i[i*STB_W +: STB_W];
		ftu_event_gen u_evt (
			.sys_clk_i(sys_clk_i),
			.resetn_i(resetn_i),
			.enable_i(event_enable_i[i]),
			.boundary_i((sel <= STB_DL_FRM) ? strobes[sel] : 1'b0),
			.offset_i(event_offset_i[i*EVT_W +: EVT_W]),
			.modulo_i(event_modulo_i[i*EVT_W +: EVT_W]),
			.event_o(event_o[i])
		);
	end
	assign link_clk_count_o = r.lc;
	assign link_frame_count_o = r.lf;
	assign radio_clk_count_o = r.rc;
	assign link_frame_strobe_o = r.lfb;
	assign radio_symbol_strobe_o = r.rsb;
	assign radio_frame_strobe_o = r.rfb;
	assign uplink_symbol_strobe_o = r.usb;
	assign uplink_frame_strobe_o = r.ufb;
	assign downlink_symbol_strobe_o = r.dsb;
	assign downlink_frame_strobe_o = r.dfb;
	assign tx_launch_o = r.tx;
	assign rx_in_window_o = r.rxw;
	a_link_sync_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		link_sync |=> (link_clk_count_o == '0 && link_frame_strobe_o)) else $error("link sync");
	a_radio_sync_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		radio_sync |=> (radio_clk_count_o == '0 && radio_frame_strobe_o)) else $error("radio sync");
	a_compare_sync: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		(timer_control_one_i[CTL_RAD_LSB +: 3] == RSYNC_CMP && cmp_hit) |=> radio_clk_count_o == '0)
		else $error("compare sync");
	a_link_counts: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		(!link_sync && r.lc != clk_terminal_i) |=> link_clk_count_o == $past(r.lc) + 1'b1)
		else $error("link count");
	a_link_keeps_radio: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		(link_sync && !radio_sync && r.rc != rclk_terminal_i) |=> r.rs == $past(r.rs))
		else $error("link sync moved radio count");
	a_copy_offsets: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		(radio_sync && uplink_offset_i <= rclk_terminal_i && downlink_offset_i <= rclk_terminal_i)
		|=> (r.uc == $past(uplink_offset_i) && r.dc == $past(downlink_offset_i)))
		else $error("copy offset");
	a_frame_has_sym: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		radio_frame_strobe_o |-> radio_symbol_strobe_o) else $error("frame without symbol");
	a_tx_launch: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		tx_launch_o |-> link_clk_count_o == tx_delta_i) else $error("tx launch");
	c_link_sync: cover property (@(posedge sys_clk_i) link_sync);
	c_radio_cmp: cover property (@(posedge sys_clk_i) timer_control_one_i[4:2] == RSYNC_CMP && cmp_hit);
	c_ul_frame: cover property (@(posedge sys_clk_i) uplink_frame_strobe_o);
endmodule
`default_nettype wire

// ### logic/ftu_pkg.sv
// Summary of operation
// - link and radio timers count independently, concurrently
// - both timers run on processing clock
// - link sync source: rp1, pin, software, received
// - radio sync adds code four, link compare
// - link count equal compare value syncs radio
// - syncs accepted together or apart
// - link timer gives tx/rx window references
// - uplink, downlink radio copies offset by programmed amount
// - each radio timer gives symbol, frame strobes
// - events counter based, no mask patterns
// - event delayed by offset after boundary
// - modulo counter repeats event between boundaries
// - enable/disable changes take effect at boundary
// - three nested counts with programmable terminals
package ftu_pkg;
	localparam int CLK_W = 20;
	localparam int SYM_W = 8;
	localparam int FRM_W = 12;
	localparam int EVT_W = 20;
	localparam int NUM_EVT = 4;
	localparam int STB_W = 3;
	localparam logic [1:0] SYNC_RP1 = 2'h0;
	localparam logic [1:0] SYNC_PIN = 2'h1;
	localparam logic [1:0] SYNC_SW = 2'h2;
	localparam logic [1:0] SYNC_RXFB = 2'h3;
	localparam logic [2:0] RSYNC_CMP = 3'h4;
	localparam int CTL_LINK_LSB = 0;
	localparam int CTL_RAD_LSB = 2;
	localparam logic [31:0] CTL_RESET = 32'h0;
	localparam logic [STB_W-1:0] STB_RAD_SYM = 3'h0;
	localparam logic [STB_W-1:0] STB_RAD_FRM = 3'h1;
	localparam logic [STB_W-1:0] STB_UL_SYM = 3'h2;
	localparam logic [STB_W-1:0] STB_UL_FRM = 3'h3;
	localparam logic [STB_W-1:0] STB_DL_SYM = 3'h4;
	localparam logic [STB_W-1:0] STB_DL_FRM = 3'h5;
	typedef enum logic [1:0] {EV_IDLE, EV_WAIT, EV_RUN} ftu_evstate_type;
endpackage

// ### logic/ftu_event_gen.sv
`timescale 1ns/10ps
`default_nettype none
module ftu_event_gen (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic enable_i,
	input wire logic boundary_i,
	input wire logic [ftu_pkg::EVT_W-1:0] offset_i,
	input wire logic [ftu_pkg::EVT_W-1:0] modulo_i,
	output logic event_o
);
	import ftu_pkg::*;
	typedef struct packed {
		ftu_evstate_type st;
		logic [EVT_W-1:0] cnt;
		logic ev;
	} ftu_eg_type;
	ftu_eg_type r, next_r;
	always_comb begin
		next_r = r;
		next_r.ev = 1'b0;
		case (r.st)
			EV_IDLE: begin
				if (boundary_i && enable_i) begin
					next_r.st = EV_WAIT;
					next_r.cnt = '0;
					next_r.ev = (offset_i == '0);
					if (offset_i == '0) begin
						next_r.st = EV_RUN;
					end
				end
			end
			EV_WAIT: begin
				next_r.cnt = r.cnt + 1'b1;
				if (r.cnt + 1'b1 == offset_i) begin
					next_r.st = EV_RUN;
					next_r.cnt = '0;
					next_r.ev = 1'b1;
				end
			end
			EV_RUN: begin
				next_r.cnt = r.cnt + 1'b1;
				if (r.cnt == modulo_i) begin
					next_r.cnt = '0;
					next_r.ev = 1'b1;
				end
			end
			default: next_r.st = EV_IDLE;
		endcase
		if (boundary_i && r.st != EV_IDLE) begin
			next_r.cnt = '0;
			next_r.st = enable_i ? ((offset_i == '0) ? EV_RUN : EV_WAIT) : EV_IDLE;
			next_r.ev = enable_i && (offset_i == '0);
		end
	end
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			r <= '{st: EV_IDLE, cnt: '0, ev: 1'b0};
		end else begin
			r <= next_r;
		end
	end
	assign event_o = r.ev;
	a_disabled_quiet: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		(boundary_i && !enable_i) |=> !event_o) else $error("event after disable");
	a_offset_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		(boundary_i && enable_i && offset_i == '0) |=> event_o) else $error("no event");
	c_event: cover property (@(posedge sys_clk_i) event_o ##1 !event_o [*2] ##1 event_o);
endmodule
`default_nettype wire

// ### bench/ftu_event_sink.sv
`timescale 1ns/10ps
`default_nettype none
module ftu_event_sink (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic event_i,
	input wire logic boundary_i,
	output logic [15:0] count_o,
	output logic [15:0] gap_o,
	output logic gap_valid_o
);
	logic [15:0] since;
	logic crossed;
	// gap only reported between two events of one boundary period
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count_o <= 16'h0;
			gap_o <= 16'h0;
			gap_valid_o <= 1'b0;
			since <= 16'h0;
			crossed <= 1'b1;
		end else begin
			since <= event_i ? 16'h0 : since + 16'h1;
			gap_valid_o <= event_i & ~crossed & ~boundary_i;
			gap_o <= since + 16'h1;
			if (event_i) count_o <= count_o + 16'h1;
			if (boundary_i) crossed <= 1'b1;
			else if (event_i) crossed <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### bench/frame_timer_event_gen_test.sv
`timescale 1ns/10ps
`default_nettype none
module frame_timer_event_gen_test;
	import ftu_pkg::*;
	logic sys_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [31:0] ctl = 32'h1c;
	logic sw = 1'b0, rp1 = 1'b0, rxf = 1'b0, lpin = 1'b0, rpin = 1'b0;
	logic [CLK_W-1:0] cmp = 20'h5, ulo = 20'h0, dlo = 20'h0, rterm = 20'h9;
	logic [CLK_W-1:0] txd = 20'h14, wmin = 20'ha, wmax = 20'hc;
	logic [NUM_EVT-1:0] en = 4'h0;
	logic [NUM_EVT*STB_W-1:0] sel = 12'h0;
	logic [NUM_EVT*EVT_W-1:0] off = 80'h0, mdl = 80'h0;
	logic [CLK_W-1:0] lcnt, rcnt;
	logic lfs, rss, rfs, txl, rxw, gv;
	logic uss, dss;
	logic [FRM_W-1:0] lfn;
	logic [CLK_W-1:0] ulo_q = 20'h0, dlo_q = 20'h0;
	logic [NUM_EVT-1:0] ev;
	logic [15:0] ecnt, gap, seed = 16'h2135;
	logic [31:0] cyc = 32'h0, exp_gap = 32'h0, snap;
	int n_fail = 0, tests_run = 0, n_link = 0, n_tx = 0;
	logic [31:0] lq[$], rq[$];

	ftu_frame_timer u_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
		.timer_control_one_i(ctl), .software_sync_trigger_i(sw), .rp1_sync_i(rp1),
		.rx_frame_boundary_i(rxf), .link_sync_input_i(lpin), .radio_sync_input_i(rpin),
		.clk_terminal_i(20'hfffff), .sym_terminal_i(8'hff), .frm_terminal_i(12'hfff),
		.rclk_terminal_i(rterm), .rsym_terminal_i(8'hff), .rfrm_terminal_i(12'hfff),
		.radio_sync_compare_value_i(cmp), .tx_delta_i(txd), .rx_win_min_i(wmin),
		.rx_win_max_i(wmax), .uplink_offset_i(ulo), .downlink_offset_i(dlo),
		.event_enable_i(en), .event_strobe_sel_i(sel), .event_offset_i(off),
		.event_modulo_i(mdl), .link_clk_count_o(lcnt), .link_frame_count_o(lfn),
		.radio_clk_count_o(rcnt), .link_frame_strobe_o(lfs), .radio_symbol_strobe_o(rss),
		.radio_frame_strobe_o(rfs), .uplink_symbol_strobe_o(uss), .uplink_frame_strobe_o(),
		.downlink_symbol_strobe_o(dss), .downlink_frame_strobe_o(), .tx_launch_o(txl),
		.rx_in_window_o(rxw), .event_o(ev));

	ftu_event_sink u_sink (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .event_i(ev[0]),
		.boundary_i(rss), .count_o(ecnt), .gap_o(gap), .gap_valid_o(gv));

	always #25 sys_clk_i = ~sys_clk_i;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// radio clock count at which a copy shifted by o wraps to zero
	function automatic logic [31:0] sym_phase(input logic [CLK_W-1:0] o);
		return (o == '0) ? 32'h0 : 32'(rterm) + 32'h1 - 32'(o);
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] expv);
		tests_run++;
		if (seen !== expv) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, expv, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// which: 0 rp1, 1 pins, 2 software, 3 received boundary; lat 0 means no link sync expected
	task automatic pulse(input int which, input int both, input int lat);
		@(posedge sys_clk_i);
		if (lat != 0) begin
			lq.push_back(cyc + 32'(lat));
			n_link++;
		end
		if (both != 0) rq.push_back(cyc + 32'(lat));
		case (which)
			0: rp1 <= 1'b1;
			1: begin
				lpin <= 1'b1;
				rpin <= 1'b1;
			end
			2: sw <= 1'b1;
			default: rxf <= 1'b1;
		endcase
		@(posedge sys_clk_i);
		rp1 <= 1'b0;
		sw <= 1'b0;
		rxf <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		lpin <= 1'b0;
		rpin <= 1'b0;
		repeat (30) @(posedge sys_clk_i);
	endtask

	always @(posedge sys_clk_i) begin
		cyc <= cyc + 32'h1;
		ulo_q <= ulo;
		dlo_q <= dlo;
		if (uss === 1'b1) check("uplink symbol phase", 32'(rcnt), sym_phase(ulo_q));
		if (dss === 1'b1) check("downlink symbol phase", 32'(rcnt), sym_phase(dlo_q));
		if (lfs === 1'b1) begin
			check("link count", 32'(lcnt), 32'h0);
			check("link frame count", 32'(lfn), 32'h0);
			check("link sync cycle", cyc, (lq.size() != 0) ? lq.pop_front() : 32'hffffffff);
		end
		if (rfs === 1'b1) begin
			check("radio count", 32'(rcnt), 32'h0);
			check("radio symbol strobe", 32'(rss), 32'h1);
			check("radio sync cycle", cyc, (rq.size() != 0) ? rq.pop_front() : 32'hffffffff);
		end
		if (lcnt === 20'hb) check("rx window in", 32'(rxw), 32'h1);
		if (lcnt === 20'h1e) check("rx window out", 32'(rxw), 32'h0);
		if (txl === 1'b1) n_tx++;
		if (gv === 1'b1) check("event gap", 32'(gap), exp_gap);
	end

	always @(posedge sys_clk_i) begin
		if (cyc > 32'd3000) begin
			n_fail++;
			$display("ERROR cycle limit expected %0d seen %0d", 3000, cyc);
			tally_and_finish();
		end
	end

	initial begin
		repeat (2) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			@(posedge sys_clk_i);
			ctl <= 32'(c) | (32'(c) << 2);
			pulse(c, 1, (c == 1) ? 4 : 2);
		end
		$display("test sync sources done");
		@(posedge sys_clk_i);
		ctl <= 32'h12;
		rq.push_back(cyc + 32'd4 + 32'(cmp));
		pulse(2, 0, 2);
		$display("test radio compare done");
		ctl <= 32'h1e;
		pulse(0, 0, 0);
		$display("test unselected source done");
		seed = lfsr(seed);
		ulo <= 20'(seed[3:2]);
		dlo <= 20'(seed[5:4]);
		mdl <= {4{20'(seed[1:0]) + 20'h1}};
		exp_gap <= 32'(seed[1:0]) + 32'h2;
		sel <= {STB_DL_SYM, STB_UL_FRM, STB_RAD_FRM, STB_RAD_SYM};
		en <= 4'hf;
		repeat (60) @(posedge sys_clk_i);
		check("event seen", 32'(ecnt != 16'h0), 32'h1);
		en <= 4'he;
		@(posedge sys_clk_i);
		for (int i = 0; i < 40 && rss !== 1'b1; i++) @(posedge sys_clk_i);
		repeat (2) @(posedge sys_clk_i);
		snap = 32'(ecnt);
		repeat (30) @(posedge sys_clk_i);
		check("event stopped", 32'(ecnt), snap);
		en <= 4'hf;
		repeat (30) @(posedge sys_clk_i);
		check("event restarted", 32'(32'(ecnt) != snap), 32'h1);
		$display("test events done");
		check("tx launches", 32'(n_tx), 32'(n_link));
		tally_and_finish();
	end
endmodule
`default_nettype wire
